// ### hw/fsr_params.svh
// Purpose: Constants for the fan speed and threshold register group.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes:   Offsets, reset values and timing counts live here.
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH
`define FSR_A_PER_LO    8'h08
`define FSR_A_PER_HI    8'h09
`define FSR_A_STATUS    8'h0C
`define FSR_A_MIN_LO    8'h10
`define FSR_A_MIN_HI    8'h11
`define FSR_A_MAX_LO    8'h12
`define FSR_A_MAX_HI    8'h13
`define FSR_A_LCRIT     8'h1B
`define FSR_A_PSV       8'h1C
`define FSR_A_RCRIT     8'h1D
`define FSR_A_TGT_LO    8'h1E
`define FSR_A_TGT_HI    8'h1F
`define FSR_R_ZERO      8'h00
`define FSR_R_FF        8'hFF
`define FSR_R_LCRIT     8'h50
`define FSR_R_RCRIT     8'h69
`define FSR_PSV_MASK    8'h3F
`define FSR_TOL         16'h000A
`define FSR_DUTY_OFF    8'h00
`define FSR_TEMP_LSBS   3'h0
`endif

// ### hw/fsr_pkg.sv
// Purpose: Shared types for the fan speed register group.
// Assumes: Included constants come from fsr_params.svh.
// Notes:   Host sequencer states live here.
package fsr_pkg;
    typedef enum logic [1:0] {
        FSR_H_IDLE = 2'b00,
        FSR_H_RDLO = 2'b01,
        FSR_H_RDHI = 2'b10,
        FSR_H_WR   = 2'b11
    } fsr_hstate_type;
endpackage : fsr_pkg

// ### hw/fsr_bus_if.sv
// Purpose: Register port joining the host end and the device end.
// Assumes: One access per cycle, read data valid the cycle after.
// Notes:   No clocking block; both ends share mclk_in.
`timescale 1ns/1ns
`default_nettype none
interface fsr_bus_if;
    logic       wr_en;   // Write strobe, one cycle.
    logic       rd_en;   // Read strobe, one cycle.
    logic [7:0] addr;    // Register address.
    logic [7:0] wdata;   // Write data.
    logic [7:0] rdata;   // Read data, registered.
    logic       rvalid;  // Read data valid pulse.
    modport dev  (input wr_en, rd_en, addr, wdata, output rdata, rvalid);
    modport host (output wr_en, rd_en, addr, wdata, input rdata, rvalid);
endinterface : fsr_bus_if
`default_nettype wire

// ### hw/fsr_dev.sv
// What this block does
// RULE1 - Local critical threshold at 0x1B, reset 0x50.
// RULE2 - Remote critical threshold at 0x1D, reset 0x69.
// RULE3 - Passive threshold 0x1C keeps bits 5..0 only.
// RULE4 - Auto loop forces duty zero at/below passive.
// RULE5 - Period bytes 0x08/0x09 read-only, reset zero.
// RULE6 - Low byte read freezes high until both read.
// RULE7 - Host reads period low byte before high.
// RULE8 - Target period 0x1E/0x1F, reset 0xFF, host writes.
// RULE9 - Mode zero: target within thirty percent period.
// RULE10 - Mode one: target within slowest running period.
// RULE11 - Min speed limit 0x10/0x11; above means slow.
// RULE12 - Max speed limit 0x12/0x13; below means fast.
// RULE13 - Thresholds are eleven bits, three zero LSBs.
// RULE14 - Software mode: hold duty within 0x000A counts.
// RULE15 - Recompare limits on each new period sample.
//
// Purpose: Device end of the fan speed and threshold register group.
// Assumes: Period samples and temperatures arrive from sibling logic.
// Notes:   Status at 0x0C: bit0 too slow, bit1 too fast, bit2 in band.
`timescale 1ns/1ns
`default_nettype none
`include "fsr_params.svh"
module fsr_dev
    import fsr_pkg::*;
(
    input  wire logic        mclk_in,         // System clock.
    input  wire logic        rst_in,          // Sync reset, high.
    fsr_bus_if.dev           bus,             // Register port.
    input  wire logic        period_vld_in,   // New period sample pulse.
    input  wire logic [15:0] period_in,       // Measured period.
    input  wire logic        auto_loop_in,    // Auto temp loop active.
    input  wire logic [10:0] temp_in,         // Governing temperature.
    input  wire logic [7:0]  duty_req_in,     // Loop duty request.
    output logic      [7:0]  duty_cycle_value_out, // Duty to PWM.
    output logic      [10:0] local_critical_bits_out,  // Local limit.
    output logic      [10:0] remote_critical_bits_out, // Remote limit.
    output logic      [15:0] target_period_out,  // Software target.
    output logic             too_slow_out,    // Below min speed.
    output logic             too_fast_out,    // Above max speed.
    output logic             in_band_out      // Near target.
);
    logic [7:0]  lcrit_q, rcrit_q, psv_q;
    logic [15:0] min_q, max_q, tgt_q, per_q;
    logic [7:0]  hi_frz_q;
    logic        frz_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [15:0] diff;
    logic [10:0] psv_full;
    logic        slow_d;      // Sample below minimum speed.
    logic        fast_d;      // Sample above maximum speed.
    logic        band_d;      // Sample within tolerance of target.
    logic        lo_rd;       // Host reads the period low byte.
    logic        hi_rd;       // Host reads the period high byte.

    // Temperature thresholds; only the upper eight of eleven bits are kept.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            lcrit_q <= `FSR_R_LCRIT; // see RULE1
            rcrit_q <= `FSR_R_RCRIT; // see RULE2
            psv_q   <= `FSR_R_ZERO;  // see RULE3
        end else if (bus.wr_en) begin
            case (bus.addr)
                `FSR_A_LCRIT: lcrit_q <= bus.wdata; // see RULE1
                `FSR_A_RCRIT: rcrit_q <= bus.wdata; // see RULE2
                // Masking on the way in means bits 7..6 never read back as
                // set, so the passive threshold cannot pass its top value.
                `FSR_A_PSV:   psv_q <= bus.wdata & `FSR_PSV_MASK; // see RULE3
                default: ;
            endcase
        end
    end

    // Speed limits and target; writes to read-only offsets fall through.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            min_q <= {`FSR_R_FF, `FSR_R_FF};     // see RULE11
            max_q <= {`FSR_R_ZERO, `FSR_R_ZERO}; // see RULE12
            tgt_q <= {`FSR_R_FF, `FSR_R_FF};     // see RULE8
        end else if (bus.wr_en) begin
            case (bus.addr)
                `FSR_A_MIN_LO: min_q[7:0]  <= bus.wdata; // see RULE11
                `FSR_A_MIN_HI: min_q[15:8] <= bus.wdata;
                `FSR_A_MAX_LO: max_q[7:0]  <= bus.wdata; // see RULE12
                `FSR_A_MAX_HI: max_q[15:8] <= bus.wdata;
                // The target halves land in separate writes, so the band
                // check sees a mixed value for the access in between.
                `FSR_A_TGT_LO: tgt_q[7:0]  <= bus.wdata; // see RULE8
                `FSR_A_TGT_HI: tgt_q[15:8] <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Period capture; the host view of the high byte is held while frozen.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            per_q <= {`FSR_R_ZERO, `FSR_R_ZERO}; // see RULE5
        end else if (period_vld_in) begin
            per_q <= period_in;
        end
    end

    // Decoded period reads, shared by the freeze and its snapshot.
    assign lo_rd = bus.rd_en && (bus.addr == `FSR_A_PER_LO);
    assign hi_rd = bus.rd_en && (bus.addr == `FSR_A_PER_HI);

    // Freeze opens on a low byte read and closes on the high byte read.
    // A lone high byte read leaves it shut and returns the live value.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            frz_q <= 1'b0;
        end else if (lo_rd) begin
            frz_q <= 1'b1; // see RULE6
        end else if (hi_rd) begin
            frz_q <= 1'b0; // see RULE6
        end
    end

    // Snapshot of the high byte taken at the same edge as the low byte,
    // so a sample stored at that very edge cannot split the pair.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            hi_frz_q <= `FSR_R_ZERO;
        end else if (lo_rd) begin
            hi_frz_q <= per_q[15:8]; // see RULE6
        end
    end

    // Registered read mux; unmapped offsets answer zero.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_q  <= `FSR_R_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= bus.rd_en;
            if (bus.rd_en) begin
                case (bus.addr)
                    `FSR_A_PER_LO: rdata_q <= per_q[7:0]; // see RULE5
                    `FSR_A_PER_HI: rdata_q <= frz_q ? hi_frz_q
                                                    : per_q[15:8]; // see RULE6
                    `FSR_A_STATUS: rdata_q <= {5'h00, in_band_out,
                                               too_fast_out, too_slow_out};
                    `FSR_A_MIN_LO: rdata_q <= min_q[7:0];
                    `FSR_A_MIN_HI: rdata_q <= min_q[15:8];
                    `FSR_A_MAX_LO: rdata_q <= max_q[7:0];
                    `FSR_A_MAX_HI: rdata_q <= max_q[15:8];
                    `FSR_A_LCRIT:  rdata_q <= lcrit_q;
                    `FSR_A_PSV:    rdata_q <= psv_q; // see RULE3
                    `FSR_A_RCRIT:  rdata_q <= rcrit_q;
                    `FSR_A_TGT_LO: rdata_q <= tgt_q[7:0];
                    `FSR_A_TGT_HI: rdata_q <= tgt_q[15:8];
                    default:       rdata_q <= `FSR_R_ZERO;
                endcase
            end
        end
    end
    assign bus.rdata  = rdata_q;
    assign bus.rvalid = rvalid_q;

    // Stored bytes are the upper eight of eleven-bit thresholds.
    assign psv_full = {psv_q, `FSR_TEMP_LSBS}; // see RULE13

    // Distance to the target, taken without sign in either direction.
    assign diff = (period_in > tgt_q) ? (period_in - tgt_q)
                                      : (tgt_q - period_in);

    // Next status: a period longer than the minimum limit is a slow fan.
    assign slow_d = period_in > min_q; // see RULE11
    assign fast_d = period_in < max_q; // see RULE12
    assign band_d = diff <= `FSR_TOL;  // see RULE14

    // Limit comparisons refresh only on a new sample, so status is stable
    // between samples; a limit written later acts on the next sample.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            too_slow_out <= 1'b0;
            too_fast_out <= 1'b0;
            in_band_out  <= 1'b0;
        end else if (period_vld_in) begin
            too_slow_out <= slow_d; // see RULE15
            too_fast_out <= fast_d; // see RULE15
            in_band_out  <= band_d;
        end
    end

    // Duty: passive stop in auto loop, else follow the request; software mode holds when near target.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            duty_cycle_value_out <= `FSR_DUTY_OFF;
        end else if (auto_loop_in && temp_in <= psv_full) begin
            duty_cycle_value_out <= `FSR_DUTY_OFF; // see RULE4
        end else if (auto_loop_in || !in_band_out) begin
            duty_cycle_value_out <= duty_req_in; // see RULE14
        end
    end

    // Outputs that mirror registers; the critical limits widen to full threshold width.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            local_critical_bits_out  <= {`FSR_R_LCRIT, `FSR_TEMP_LSBS};
            remote_critical_bits_out <= {`FSR_R_RCRIT, `FSR_TEMP_LSBS};
            target_period_out        <= {`FSR_R_FF, `FSR_R_FF};
        end else begin
            // Bytes widen over three zero fraction bits, see RULE13.
            local_critical_bits_out  <= {lcrit_q, `FSR_TEMP_LSBS};
            remote_critical_bits_out <= {rcrit_q, `FSR_TEMP_LSBS};
            target_period_out        <= tgt_q;
        end
    end
endmodule : fsr_dev
`default_nettype wire

// ### hw/fsr_host.sv
// Purpose: Host end: reads the period coherently and writes registers.
// Assumes: User keeps target within the fan's valid range.
// Notes:   Period read always issues low byte then high byte.
`timescale 1ns/1ns
`default_nettype none
`include "fsr_params.svh"
module fsr_host
    import fsr_pkg::*;
(
    input  wire logic        mclk_in,      // System clock.
    input  wire logic        rst_in,       // Sync reset, high.
    fsr_bus_if.host          bus,          // Register port.
    input  wire logic        rd_per_in,    // Start 16-bit period read.
    input  wire logic        wr_in,        // Start byte write.
    input  wire logic [7:0]  wr_addr_in,   // Write address.
    input  wire logic [7:0]  wr_data_in,   // Write data.
    output logic             busy_out,     // Sequence in progress.
    output logic             per_vld_out,  // Period result pulse.
    output logic      [15:0] per_out       // Coherent period.
);
    fsr_hstate_type st_q;
    logic           wr_q, rd_q;
    logic [7:0]     addr_q, wdata_q;

    // Sequencer; low byte strictly first keeps the pair coherent.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_q <= FSR_H_IDLE; wr_q <= 1'b0; rd_q <= 1'b0;
            addr_q <= `FSR_R_ZERO; wdata_q <= `FSR_R_ZERO;
            busy_out <= 1'b0; per_vld_out <= 1'b0;
            per_out <= {`FSR_R_ZERO, `FSR_R_ZERO};
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            per_vld_out <= 1'b0;
            case (st_q)
                FSR_H_IDLE: begin
                    if (rd_per_in) begin
                        rd_q <= 1'b1; addr_q <= `FSR_A_PER_LO; // see RULE7
                        busy_out <= 1'b1; st_q <= FSR_H_RDLO;
                    end else if (wr_in) begin
                        wr_q <= 1'b1; addr_q <= wr_addr_in; // see RULE8
                        wdata_q <= wr_data_in;
                        busy_out <= 1'b1; st_q <= FSR_H_WR;
                    end
                end
                FSR_H_RDLO: begin
                    if (bus.rvalid) begin
                        per_out[7:0] <= bus.rdata;
                        rd_q <= 1'b1; addr_q <= `FSR_A_PER_HI; // see RULE7
                        st_q <= FSR_H_RDHI;
                    end
                end
                FSR_H_RDHI: begin
                    if (bus.rvalid) begin
                        per_out[15:8] <= bus.rdata;
                        per_vld_out <= 1'b1; busy_out <= 1'b0;
                        st_q <= FSR_H_IDLE;
                    end
                end
                FSR_H_WR: begin
                    busy_out <= 1'b0; st_q <= FSR_H_IDLE;
                end
                default: st_q <= FSR_H_IDLE;
            endcase
        end
    end
    assign bus.wr_en = wr_q;
    assign bus.rd_en = rd_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
endmodule : fsr_host
`default_nettype wire

// ### test/fsr_monitor.sv
// Purpose: Bus checks between the host end and the device end.
// Assumes: Signals of fsr_bus_if arrive as plain inputs.
// Notes:   The host only reads the period, low byte first.
`timescale 1ns/1ns
`default_nettype none
`include "fsr_params.svh"
module fsr_monitor (
    input  wire logic       mclk_in, // System clock.
    input  wire logic       rst_in,  // Sync reset, high.
    input  wire logic       wr_en,   // Write strobe.
    input  wire logic       rd_en,   // Read strobe.
    input  wire logic [7:0] addr,    // Register address.
    input  wire logic [7:0] wdata,   // Write data.
    input  wire logic [7:0] rdata,   // Read data.
    input  wire logic       rvalid   // Read data valid.
);
    // One clock domain, so reset mutes every check at once.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_low_then_high: assert property (
        rd_en && addr == `FSR_A_PER_LO
        |-> ##2 (rd_en && addr == `FSR_A_PER_HI))
        else $error("High byte read did not follow the low byte.");
    a_high_after_low: assert property (
        rd_en && addr == `FSR_A_PER_HI
        |-> $past(rd_en, 2) && $past(addr, 2) == `FSR_A_PER_LO)
        else $error("High byte read without a low byte read.");
    a_read_answers: assert property (
        rd_en |=> rvalid)
        else $error("Read got no valid pulse.");
    a_valid_has_cause: assert property (
        rvalid |-> $past(rd_en))
        else $error("Valid pulse without a read.");
    a_rdata_holds: assert property (
        !rd_en |=> $stable(rdata))
        else $error("Read data moved without a read.");
    a_pair_answers: assert property (
        rd_en && addr == `FSR_A_PER_LO
        |-> ##1 rvalid ##1 !rvalid ##1 rvalid ##1 !rvalid)
        else $error("Period pair did not answer twice.");
    a_write_single: assert property (
        wr_en |=> !wr_en)
        else $error("Write strobe longer than one cycle.");
    a_no_overlap: assert property (
        !(wr_en && rd_en))
        else $error("Read and write in the same cycle.");
    // Main traffic: period pair, passive threshold and target writes.
    c_period_read: cover property (rd_en && addr == `FSR_A_PER_LO);
    c_psv_write: cover property (wr_en && addr == `FSR_A_PSV);
    c_target_write: cover property (wr_en && addr == `FSR_A_TGT_LO);
endmodule : fsr_monitor
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the host and device ends.
// Assumes: Inputs change on the falling edge of mclk_in.
// Notes:   Registered outputs are sampled two edges after their cause.
`timescale 1ns/1ns
`default_nettype none
`include "fsr_params.svh"
module testbench;
    logic        mclk_in = 1'b0, rst_in = 1'b1, pvld = 1'b0, wr = 1'b0;
    logic        auto_loop = 1'b0, rd_per = 1'b0;
    logic        busy, per_vld, slow, fast, band;
    logic [15:0] period = '0, per, tgt;
    logic [10:0] temp = '0, lcrit, rcrit;
    logic [7:0]  duty_req = '0, wa = '0, wd = '0, duty;
    int          fail_count = 0, compares = 0;
    fsr_bus_if bus ();
    fsr_dev i_fsr_dev (.mclk_in(mclk_in), .rst_in(rst_in), .bus(bus),
        .period_vld_in(pvld), .period_in(period), .auto_loop_in(auto_loop),
        .temp_in(temp), .duty_req_in(duty_req), .duty_cycle_value_out(duty),
        .local_critical_bits_out(lcrit), .remote_critical_bits_out(rcrit),
        .target_period_out(tgt), .too_slow_out(slow), .too_fast_out(fast),
        .in_band_out(band));
    fsr_host i_fsr_host (.mclk_in(mclk_in), .rst_in(rst_in), .bus(bus),
        .rd_per_in(rd_per), .wr_in(wr), .wr_addr_in(wa), .wr_data_in(wd),
        .busy_out(busy), .per_vld_out(per_vld), .per_out(per));
    fsr_monitor i_fsr_monitor (.mclk_in(mclk_in), .rst_in(rst_in),
        .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
        .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));
    // Free-running 50 MHz clock.
    always #10 mclk_in = ~mclk_in;
    // Counts every compare and reports a mismatch on the spot.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Mismatches %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // Byte write through the host end; waits out busy with a bound.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        wa = a;
        wd = d;
        @(negedge mclk_in);
        wr = 1'b0;
        for (int i = 0; i < 8 && busy !== 1'b0; i++) @(negedge mclk_in);
        // One more edge so the registered mirrors show the new value.
        @(negedge mclk_in);
    endtask : reg_write
    task automatic period_read(output logic [15:0] v);
        rd_per = 1'b1;
        @(negedge mclk_in);
        rd_per = 1'b0;
        for (int i = 0; i < 8 && per_vld !== 1'b1; i++) @(negedge mclk_in);
        check(16'(per_vld), 16'h0001);
        v = per;
    endtask : period_read
    task automatic sample(input logic [15:0] p);
        period = p;
        pvld = 1'b1;
        @(negedge mclk_in);
        pvld = 1'b0;
        @(negedge mclk_in);
    endtask : sample
    // Thresholds come out as the stored byte shifted up three places.
    task automatic t_reset();
        logic [15:0] v;
        check(16'(lcrit), 16'h0280);
        check(16'(rcrit), 16'h0348);
        check(tgt, 16'hFFFF);
        period_read(v);
        check(v, 16'h0000);
    endtask : t_reset
    // Stored bits 7..6 would lift the passive threshold to 0x7F8.
    task automatic t_thresh();
        reg_write(`FSR_A_LCRIT, 8'hA5);
        check(16'(lcrit), 16'h0528);
        reg_write(`FSR_A_RCRIT, 8'h3C);
        check(16'(rcrit), 16'h01E0);
        reg_write(`FSR_A_PSV, 8'hFF);
        auto_loop = 1'b1;
        duty_req = 8'h80;
        temp = 11'h1F9;
        repeat (2) @(negedge mclk_in);
        check(16'(duty), 16'h0080);
        temp = 11'h1F8;
        repeat (2) @(negedge mclk_in);
        check(16'(duty), 16'h0000);
    endtask : t_thresh
    // Boundary samples on both limits, then a sample with no strobe.
    task automatic t_limits();
        logic [15:0] lp [4] = '{16'h1001, 16'h07FF, 16'h1000, 16'h0800};
        logic [1:0]  le [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
        reg_write(`FSR_A_MIN_LO, 8'h00);
        reg_write(`FSR_A_MIN_HI, 8'h10);
        reg_write(`FSR_A_MAX_LO, 8'h00);
        reg_write(`FSR_A_MAX_HI, 8'h08);
        for (int i = 0; i < 4; i++) begin
            sample(lp[i]);
            check(16'({slow, fast}), 16'(le[i]));
        end
        period = 16'h0001;
        repeat (2) @(negedge mclk_in);
        check(16'({slow, fast}), 16'h0000);
    endtask : t_limits
    // A sample lands on the low byte read; the high byte must not move.
    task automatic t_coherent();
        logic [15:0] v;
        sample(16'h1234);
        fork
            period_read(v);
            begin
                @(negedge mclk_in);
                period = 16'hABCD;
                pvld = 1'b1;
                @(negedge mclk_in);
                pvld = 1'b0;
            end
        join
        check(v, 16'h1234);
        reg_write(`FSR_A_PER_HI, 8'h55);
        period_read(v);
        check(v, 16'hABCD);
    endtask : t_coherent
    // Band edges at exactly ten counts either side of the target.
    task automatic t_target();
        logic [15:0] tp [4] = '{16'h100A, 16'h100B, 16'h0FF6, 16'h0FF5};
        // Target kept well under the slowest running period.
        reg_write(`FSR_A_TGT_LO, 8'h00);
        reg_write(`FSR_A_TGT_HI, 8'h10);
        check(tgt, 16'h1000);
        for (int i = 0; i < 4; i++) begin
            sample(tp[i]);
            check(16'(band), 16'(i % 2 == 0));
        end
        // Software mode: duty follows the request until the band is hit.
        auto_loop = 1'b0;
        duty_req = 8'h40;
        repeat (2) @(negedge mclk_in);
        check(16'(duty), 16'h0040);
        sample(16'h1000);
        duty_req = 8'h20;
        repeat (2) @(negedge mclk_in);
        check(16'(duty), 16'h0040);
    endtask : t_target
    // The run needs under a thousand cycles, so 2500 means a hang.
    initial begin
        #50000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (5) @(negedge mclk_in);
        rst_in = 1'b0;
        t_reset();
        t_thresh();
        t_limits();
        t_coherent();
        t_target();
        test_done();
    end
endmodule : testbench
`default_nettype wire
